// ### rtl/adlpf_pkg.sv
// Package for the decimating low-pass filter: timing counts, scaling,
// saturation limits, settling figures and the run/sleep states.
// Assumes one master clock; every rate in the filter is a fixed count of it.
package adlpf_pkg;

   // ---------------------------------------------------------------
   // Clock-count timing
   // ---------------------------------------------------------------
   localparam int unsigned CNT_W = 10;
   localparam logic [CNT_W-1:0] FILT_CYC_LAST = 10'h3ff;   // 1024 clocks per filter cycle
   localparam logic [7:0] SAMPLE_LAST = 8'hff;             // 256 clocks per modulator sample
   localparam logic [5:0] CAP_LAST = 6'h3f;                // 64 clocks per capacitor phase
   localparam int unsigned CORNER_DIV = 409600;            // Master clock / corner frequency
   localparam int unsigned SAMPLE_DIV = 256;
   localparam int unsigned OSR = CORNER_DIV / (2 * SAMPLE_DIV); // 800

   // ---------------------------------------------------------------
   // Datapath widths and scaling
   // ---------------------------------------------------------------
   localparam int unsigned ACC_W = 9;                      // 0..256 ones per sample
   localparam int unsigned DW = 32;                        // Pole state, headroom above 20 bits
   localparam int unsigned OUT_W = 20;
   localparam int unsigned NARROW_SHIFT = 4;               // 20-bit to 16-bit word
   localparam logic [ACC_W-1:0] ZERO_CNT = 9'h010;         // Ones density at zero scale
   localparam logic signed [14:0] IN_GAIN = 15'sh1249;     // 2^20 / 224 counts of span
   localparam int unsigned POLES = 6;
   // Per-pole coefficient in Q16: six equal poles give a near-Gaussian shape
   // whose overall -3 dB point sits at sample rate / 1600.
   localparam logic signed [11:0] POLE_K = 12'sh2e1;
   localparam int unsigned K_SHIFT = 16;
   localparam logic signed [DW-1:0] FS_CODE = 32'sh0010_0000;  // First code above full scale
   localparam logic [OUT_W-1:0] ALL_ONES = 20'hfffff;
   localparam logic [OUT_W-1:0] ALL_ZEROS = 20'h00000;
   localparam logic [15:0] ALL_ONES16 = 16'hffff;

   // ---------------------------------------------------------------
   // Settling in filter cycles to half an LSB
   // ---------------------------------------------------------------
   localparam int unsigned SETTLE_W = 9;
   localparam logic [SETTLE_W-1:0] SETTLE16 = 9'h1ef;      // 495
   localparam logic [SETTLE_W-1:0] SETTLE20 = 9'h1fb;      // 507

   // ---------------------------------------------------------------
   // Run state, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ADLPF_ASLEEP = 2'b01,
      ADLPF_RUN = 2'b10
   } adlpf_mode_t;

endpackage

// ### rtl/adlpf_pole.sv
// One real pole of the cascade: y += K * (x - y), updated on en.
// Assumes en is a single-cycle strobe at the modulator sample rate.
`timescale 1ns/100ps
module adlpf_pole
   import adlpf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic en_in,
   input wire logic clr_in,
   // Data
   input wire logic signed [DW-1:0] x_in,
   output logic signed [DW-1:0] y_out
);

   typedef struct packed {
      logic signed [DW-1:0] y;
   } adlpf_pole_st_t;

   adlpf_pole_st_t st_reg;
   adlpf_pole_st_t st_next;
   logic signed [DW:0] diff;
   logic signed [DW+12:0] prod;

   // ---------------------------------------------------------------
   // Pole update
   // ---------------------------------------------------------------
   // Wide product keeps the fractional step; shift truncates toward -inf
   always_comb begin
      st_next = st_reg;
      diff = (DW+1)'(x_in) - (DW+1)'(st_reg.y);
      prod = (DW+13)'(diff) * (DW+13)'(POLE_K);
      if (clr_in) begin
         st_next.y = '0;
      end else if (en_in) begin
         st_next.y = st_reg.y + DW'(prod >>> K_SHIFT);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign y_out = st_reg.y;

endmodule // adlpf_pole

// ### rtl/adlpf_filter.sv
// Decimating low-pass filter behind a one-bit charge-balance modulator.
// Assumes the modulator bit, sleep and width pins are asynchronous and
// that ref_clk_in is the master clock from which all rates derive.
//
// Contract
// - Corner frequency equals master clock divided by 409,600.
// - At 4.096 MHz: 10 Hz corner, output updated at 4 kHz.
// - Corner and update rate scale with clock; all timing is counts.
// - Response is a six-pole Gaussian-like low-pass.
// - Datapath headroom handles excursions 100 mV beyond full scale.
// - Results above full scale saturate to all ones.
// - Modulator samples at clock/256; no rejection near its multiples.
// - Oversampling ratio 800 against twice the corner; noise to 0.035.
// - Full-scale step settles in 495 (16-bit) or 507 (20-bit) cycles.
// - Step overshoot at most about 0.25 LSB16 or 4 LSB20.
// - Every update delivers a fresh full-width word; words are correlated.
// - Results below zero scale saturate to all zeroes.
// - Sample capacitor switches between buffer and pin every 64 clocks.
// - After wake, allow settling before trusting output; keep coefficients.
`timescale 1ns/100ps
module adlpf_filter
   import adlpf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Modulator and pins
   input wire logic mod_bit_in,
   input wire logic sleep_n_in,
   input wire logic wide_in,
   // Analog switch control
   output logic cap_to_pin_out,
   output logic sample_strobe_out,
   // Result word
   output logic [OUT_W-1:0] data_out,
   output logic data_valid_out,
   output logic settled_out
);

   typedef struct packed {
      logic [1:0] mod_sync;
      logic [1:0] sleep_sync;
      logic [1:0] wide_sync;
      adlpf_mode_t mode;
      logic [CNT_W-1:0] clk_cnt;
      logic [ACC_W-1:0] ones_acc;
      logic signed [DW-1:0] x;
      logic strobe;
      logic cap_phase;
      logic [OUT_W-1:0] word;
      logic valid;
      logic [SETTLE_W-1:0] settle_cnt;
      logic settled;
   } adlpf_st_t;

   adlpf_st_t st_reg;
   adlpf_st_t st_next;
   logic signed [DW-1:0] chain [0:POLES];
   logic run;
   logic [ACC_W-1:0] sample_cnt;
   logic signed [ACC_W:0] centred;
   logic [SETTLE_W-1:0] settle_lim;

   // ---------------------------------------------------------------
   // Saturating output conversion
   // ---------------------------------------------------------------
   // Clamp is applied only to the filtered value, so noise beyond
   // full scale is averaged first rather than clipped at the input
   function automatic logic [OUT_W-1:0] sat_word(input logic signed [DW-1:0] y,
                                                 input logic wide);
      logic signed [DW-1:0] n;
      n = y >>> NARROW_SHIFT;
      if (y < 0) begin
         sat_word = ALL_ZEROS;
      end else if (y >= FS_CODE) begin
         sat_word = wide ? ALL_ONES : OUT_W'(ALL_ONES16);
      end else if (wide) begin
         sat_word = y[OUT_W-1:0];
      end else begin
         sat_word = OUT_W'(n[15:0]);
      end
   endfunction

   // ---------------------------------------------------------------
   // Six-pole cascade
   // ---------------------------------------------------------------
   assign chain[0] = st_reg.x;
   assign run = (st_reg.mode == ADLPF_RUN);

   generate
      for (genvar i = 0; i < POLES; i++) begin : g_pole
         adlpf_pole u_pole (
            .ref_clk_in(ref_clk_in),
            .sys_rst_in(sys_rst_in),
            .en_in(st_reg.strobe & run),
            .clr_in(~run),
            .x_in(chain[i]),
            .y_out(chain[i+1])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sequencing, decimation and output
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.mod_sync = {st_reg.mod_sync[0], mod_bit_in};
      st_next.sleep_sync = {st_reg.sleep_sync[0], sleep_n_in};
      st_next.wide_sync = {st_reg.wide_sync[0], wide_in};
      st_next.strobe = 1'b0;
      st_next.valid = 1'b0;
      sample_cnt = st_reg.ones_acc + ACC_W'(st_reg.mod_sync[1]);
      centred = $signed({1'b0, sample_cnt}) - $signed({1'b0, ZERO_CNT});
      settle_lim = st_reg.wide_sync[1] ? SETTLE20 : SETTLE16;
      case (st_reg.mode)
         ADLPF_ASLEEP: begin
            // Counters restart so wake-up is aligned to a fresh filter cycle
            st_next.clk_cnt = '0;
            st_next.ones_acc = '0;
            st_next.cap_phase = 1'b0;
            st_next.settle_cnt = '0;
            st_next.settled = 1'b0;
            if (st_reg.sleep_sync[1]) begin
               st_next.mode = ADLPF_RUN;
            end
         end
         ADLPF_RUN: begin
            st_next.clk_cnt = st_reg.clk_cnt + CNT_W'(1);
            st_next.ones_acc = sample_cnt;
            if (st_reg.clk_cnt[5:0] == CAP_LAST) begin
               st_next.cap_phase = ~st_reg.cap_phase;
            end
            if (st_reg.clk_cnt[7:0] == SAMPLE_LAST) begin
               // One modulator sample per 256 clocks feeds the cascade
               st_next.ones_acc = '0;
               st_next.strobe = 1'b1;
               st_next.x = DW'((DW)'(centred) * (DW)'(IN_GAIN));
            end
            if (st_reg.clk_cnt == FILT_CYC_LAST) begin
               // Four samples per output word: 1600 samples per corner period
               st_next.word = sat_word(chain[POLES], st_reg.wide_sync[1]);
               st_next.valid = 1'b1;
               // Ordered compare: a width change after settling must not run the count on and wrap it
               if (st_reg.settle_cnt < settle_lim) begin
                  st_next.settle_cnt = st_reg.settle_cnt + SETTLE_W'(1);
               end
            end
            st_next.settled = (st_reg.settle_cnt >= settle_lim);
            if (!st_reg.sleep_sync[1]) begin
               st_next.mode = ADLPF_ASLEEP;
            end
         end
         default: begin
            st_next.mode = ADLPF_ASLEEP;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
         st_reg.mode <= ADLPF_ASLEEP;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign cap_to_pin_out = st_reg.cap_phase;
   assign sample_strobe_out = st_reg.strobe;
   assign data_out = st_reg.word;
   assign data_valid_out = st_reg.valid;
   assign settled_out = st_reg.settled;

endmodule // adlpf_filter

// ### verification/adlpf_asserts.sv
// Port checker for the decimating filter: rates, holds, sleep, width.
// Assumes it is bound to adlpf_filter; one master clock.
`timescale 1ns/100ps
module adlpf_asserts
   import adlpf_pkg::*;
(
   // Clock, reset and pins
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic mod_bit_in,
   input wire logic sleep_n_in,
   input wire logic wide_in,
   // Outputs watched
   input wire logic cap_to_pin_out,
   input wire logic sample_strobe_out,
   input wire logic [OUT_W-1:0] data_out,
   input wire logic data_valid_out,
   input wire logic settled_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [9:0] gap_reg;
   logic [5:0] run_reg;
   logic [8:0] words_reg;
   logic [1:0] seen_reg;
   logic cap_q_reg;
   // Spacing counters; cleared in sleep since the design restarts its timing
   always_ff @(posedge ref_clk_in) begin
      cap_q_reg <= cap_to_pin_out;
      if (sys_rst_in || !sleep_n_in) begin
         gap_reg <= 10'h000;
         run_reg <= 6'h00;
         words_reg <= 9'h000;
         seen_reg <= 2'h0;
      end else begin
         gap_reg <= data_valid_out ? 10'h000 : gap_reg + 10'h001;
         run_reg <= (cap_to_pin_out != cap_q_reg) ? 6'h00 : run_reg + 6'h01;
         // Saturates so a long run cannot wrap the word count back below the settle limit
         words_reg <= (words_reg == 9'h1ff) ? words_reg : words_reg + {8'h00, data_valid_out};
         seen_reg <= seen_reg | {data_valid_out, cap_to_pin_out != cap_q_reg};
      end
   end
   a_strobe_period: assert property (disable iff (sys_rst_in || !sleep_n_in)
      sample_strobe_out |-> ##256 sample_strobe_out) else $error("strobe spacing wrong");
   a_word_period: assert property (data_valid_out && seen_reg[1] |-> gap_reg == 10'h3ff)
      else $error("word spacing wrong");
   a_word_on_strobe: assert property (data_valid_out |-> sample_strobe_out)
      else $error("word without sample");
   a_cap_period: assert property ((cap_to_pin_out != cap_q_reg) && seen_reg[0] |-> run_reg == 6'h3f)
      else $error("cap phase length wrong");
   a_word_held: assert property ($changed(data_out) && sleep_n_in && $past(sleep_n_in, 4) |-> data_valid_out)
      else $error("word changed between updates");
   a_sleep_quiet: assert property (!sleep_n_in [*8] |-> !data_valid_out && !sample_strobe_out && !settled_out)
      else $error("activity in sleep");
   a_settle_late: assert property (settled_out |-> words_reg >= SETTLE16)
      else $error("settled too early");
   a_narrow_word: assert property (data_valid_out && !wide_in && !$past(wide_in, 4) |-> data_out[19:16] == 4'h0)
      else $error("narrow word top bits set");
endmodule // adlpf_asserts

bind adlpf_filter adlpf_asserts chk_u (.ref_clk_in, .sys_rst_in, .mod_bit_in, .sleep_n_in, .wide_in,
   .cap_to_pin_out, .sample_strobe_out, .data_out, .data_valid_out, .settled_out);

// ### verification/adlpf_modulator.sv
// Modulator stand-in: one bit per clock at a set ones density.
// Assumes the bench holds density steady; 256 clocks form one sample.
`timescale 1ns/100ps
module adlpf_modulator
   import adlpf_pkg::*;
(
   // Clock and density
   input wire logic ref_clk_in,
   input wire logic [ACC_W-1:0] density_in,
   // Bitstream
   output logic mod_bit_out
);
   logic [7:0] phase_reg = 8'h00;
   // Ones first in each window; only the count per sample matters
   always_ff @(posedge ref_clk_in) begin
      phase_reg <= phase_reg + 8'h01;
   end
   assign mod_bit_out = {1'b0, phase_reg} < density_in;
endmodule // adlpf_modulator

// ### verification/adlpf_filter_test.sv
// Bench for the decimating filter: rates, floor, rise, width, sleep.
// Assumes the modulator model feeds the bitstream; 100 MHz clock.
`timescale 1ns/100ps
module adlpf_filter_test
   import adlpf_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic sleep_n_in = 1'b1;
   logic wide_in = 1'b1;
   logic [ACC_W-1:0] density = 9'h000;
   logic mod_bit, cap, strobe, valid, settled;
   logic [OUT_W-1:0] data, last;
   int error_cnt = 0;
   int comparisons = 0;
   adlpf_modulator mod_u (.ref_clk_in, .density_in(density), .mod_bit_out(mod_bit));
   adlpf_filter dut_u (.ref_clk_in, .sys_rst_in, .mod_bit_in(mod_bit), .sleep_n_in, .wide_in,
      .cap_to_pin_out(cap), .sample_strobe_out(strobe), .data_out(data), .data_valid_out(valid),
      .settled_out(settled));
   // Master clock
   always #5 ref_clk_in = ~ref_clk_in;
   // Count comparison; four-state arguments so an unknown result cannot pass
   task automatic chk_num(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask
   // Bounded wait for the next word, one filter cycle plus slack
   task automatic next_word();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (valid !== 1'b1 && n < 1100);
      chk_num("word wait", 1, int'(n < 1100));
   endtask
   task automatic test_rates();
      int s, v, c;
      logic cq;
      s = 0; v = 0; c = 0;
      next_word();
      cq = cap;
      repeat (4096) begin
         @(posedge ref_clk_in);
         s += int'(strobe);
         v += int'(valid);
         c += int'(cap !== cq);
         cq = cap;
      end
      chk_num("samples", 16, s);
      chk_num("words", 4, v);
      chk_num("cap flips", 64, c);
      $display("test_rates done");
   endtask
   // Below zero scale the word floors at zero; the host averages the words it takes.
   // Host spacing of 200 filter cycles would outrun this bench, so words are consecutive
   task automatic test_floor();
      logic [31:0] sum;
      sum = '0;
      repeat (3) begin
         next_word();
         chk_num("floor word", 0, 32'(data));
         sum = sum + 32'(data);
      end
      chk_num("floor mean", 0, sum / 3);
      $display("test_floor done");
   endtask
   // Over-range step: words climb without wrapping
   task automatic test_rise();
      density <= 9'h100;
      last = '0;
      repeat (40) begin
         next_word();
         chk_num("rising", 1, 32'(data >= last));
         last = data;
      end
      chk_num("moved", 1, 32'(data > 20'h00000));
      chk_num("settled", 0, 32'(settled));
      $display("test_rise done");
   endtask
   task automatic test_narrow();
      wide_in <= 1'b0;
      repeat (3) next_word();
      chk_num("narrow top", 0, 32'(data[19:16]));
      chk_num("narrow scale", 1, 32'(data[15:0] >= last[19:4]));
      last = data << 4;
      wide_in <= 1'b1;
      next_word();
      $display("test_narrow done");
   endtask
   // Sleep stops words and clears the filter
   task automatic test_sleep();
      int v;
      v = 0;
      sleep_n_in <= 1'b0;
      repeat (200) begin
         @(posedge ref_clk_in);
         v += int'((valid | strobe | settled) !== 1'b0);
      end
      chk_num("sleep activity", 0, v);
      sleep_n_in <= 1'b1;
      next_word();
      chk_num("restart", 1, 32'(data < last));
      $display("test_sleep done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      test_rates();
      test_floor();
      test_rise();
      test_narrow();
      test_sleep();
      stop_test();
   end
   // Watchdog: tests need about 55k clocks; limit is 80k clocks
   initial begin
      #800_000;
      error_cnt++;
      stop_test();
   end
endmodule // adlpf_filter_test
